// [logic/htr_pkg.sv]
/*
  Constants for the haptic trigger and status register bank: register
  indices, field positions, reset values and edge codes.
  Assumes an APB slave with 32-bit data, one register per aligned word,
  byte address equal to four times the register index.
*/
// Functional notes
// R1: Second trigger config holds a 4-bit sequence select in bits 6:3, reset one.
// R2: Config bit 2 picks single (0) or multi (1) sequence mode, reset zero.
// R3: Config bits 1:0 pick rising, falling or both edges; reset rising.
// R4: Third trigger has the same config fields; its sequence select resets to two.
// R5: Read-only snippet memory start address reads 0x84.
// R6: Memory control bit 7 gates waveform memory: zero locked, one unlocked (reset).
// R7: Supply value is high byte times 128 plus 7-bit low part, 0.1831mV per count.
// R8: Supply high and low read 0xFF and 0x7F until a measurement arrives.
// R9: Read-only bit 0 shows the drive polarity applied now, reset zero.
// R10: Mean resonant period over four half-periods, high/low pair, both reset zero.
// R11: Live resonant period over one half-period, pair resets 0x21 and 0x4F.
// R12: Software writes phase delay high only as 0x00 or 0x25; reset 0x25.
// R13: Software sets the delay freeze bit only in wideband without tracking.
// R14: Software writes delay shift only as 0 or 5; field resets to five.
// R15: Phase delay settings act only while custom wave mode is selected.
// R16: Trigger pins are synchronised before edge detection, one event per edge.
package htr_pkg;

  localparam int ADDR_W = 10;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TRIG_ONE   = 8'h2A;
  localparam logic [7:0] IDX_TRIG_TWO   = 8'h2B;
  localparam logic [7:0] IDX_MEM_BASE   = 8'h2C;
  localparam logic [7:0] IDX_MEM_LOCK   = 8'h2D;
  localparam logic [7:0] IDX_SUPPLY_H   = 8'h2E;
  localparam logic [7:0] IDX_SUPPLY_L   = 8'h2F;
  localparam logic [7:0] IDX_POLARITY   = 8'h43;
  localparam logic [7:0] IDX_AVG_H      = 8'h44;
  localparam logic [7:0] IDX_AVG_L      = 8'h45;
  localparam logic [7:0] IDX_ACT_H      = 8'h46;
  localparam logic [7:0] IDX_ACT_L      = 8'h47;
  localparam logic [7:0] IDX_PHASE_H    = 8'h48;
  localparam logic [7:0] IDX_PHASE_L    = 8'h49;

  // Trigger config fields
  localparam int SEQ_MSB    = 6;
  localparam int SEQ_LSB    = 3;
  localparam int MULTI_BIT  = 2;
  localparam int EDGE_MSB   = 1;
  localparam int EDGE_LSB   = 0;

  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;

  localparam logic [3:0] TRIG_ONE_SEQ_RST = 4'h1;
  localparam logic [3:0] TRIG_TWO_SEQ_RST = 4'h2;
  localparam logic       MULTI_RST        = 1'b0;
  localparam logic [1:0] EDGE_RST         = 2'h0;

  // Memory fields
  localparam logic [7:0] SNIPPET_BASE = 8'h84;
  localparam int         GATE_BIT     = 7;
  localparam logic       GATE_RST     = 1'b1;

  // Measurement split: value = high * 128 + low
  localparam int         LOW_W        = 7;
  localparam logic [7:0] SUPPLY_H_RST = 8'hFF;
  localparam logic [6:0] SUPPLY_L_RST = 7'h7F;
  localparam logic       POLARITY_RST = 1'b0;
  localparam logic [7:0] AVG_H_RST    = 8'h00;
  localparam logic [6:0] AVG_L_RST    = 7'h00;
  localparam logic [7:0] ACT_H_RST    = 8'h21;
  localparam logic [6:0] ACT_L_RST    = 7'h4F;

  // Phase delay fields
  localparam logic [7:0] PHASE_H_RST  = 8'h25;
  localparam int         FREEZE_BIT   = 7;
  localparam logic       FREEZE_RST   = 1'b0;
  localparam int         SHIFT_MSB    = 2;
  localparam logic [2:0] SHIFT_RST    = 3'h5;

  localparam logic [7:0] UNMAPPED_RD  = 8'h00;

endpackage

// [logic/htr_trig_edge.sv]
/*
  One trigger pin: three-stage synchroniser, agreement filter and edge
  selection producing a one-cycle event pulse.
  Assumes the pin is asynchronous to pclk and edge_sel is a pclk register.
*/
module htr_trig_edge
  import htr_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pin and selection
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  // Result
  output logic            level,
  output logic            trig_event
);

  logic sync1;
  logic sync2;
  logic sync3;
  logic prev_level;
  logic rise;
  logic fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
    end else begin
      sync1 <= pin;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A change counts only once two later stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
    end else if (sync2 == sync3) begin
      level <= sync3; // R16
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_level <= 1'b0;
    end else begin
      prev_level <= level;
    end
  end

  assign rise = level && !prev_level;
  assign fall = !level && prev_level;

  // Code 3 is reserved and fires nothing
  always_comb begin
    unique case (edge_sel)
      EDGE_RISE: trig_event = rise; // R3
      EDGE_FALL: trig_event = fall; // R3
      EDGE_BOTH: trig_event = rise || fall; // R3
      default:   trig_event = 1'b0;
    endcase
  end

  one_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_event |=> !trig_event) // R16
    else $error("trigger event lasted more than one cycle");

  edge_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    trig_event |-> (edge_sel == EDGE_BOTH) || (edge_sel == EDGE_RISE && level) ||
                   (edge_sel == EDGE_FALL && !level)) // R3
    else $error("trigger event on unselected edge");

  pin_to_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    ($rose(pin) && edge_sel == EDGE_RISE && !level) ##1 (pin && edge_sel == EDGE_RISE) [*4]
    |-> ##[0:1] trig_event) // R16
    else $error("stable rising pin gave no event");

endmodule

// [logic/htr_trigger_regs.sv]
/*
  Haptic trigger configuration and status register bank on APB: two
  trigger input configs with edge detection, waveform memory base and
  gate, supply and resonant period readback, phase delay settings.
  Assumes measurement strobes and polarity come from logic on pclk;
  trigger pins are asynchronous.
*/
// The APB register port was decided locally.
module htr_trigger_regs
  import htr_pkg::*;
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Trigger pins and launch requests
  input  wire logic [1:0]        trigger_input,
  output logic [1:0]             trig_event,
  output logic [3:0]             trig_one_seq_select,
  output logic                   trig_one_multi_select,
  output logic [3:0]             trig_two_seq_select,
  output logic                   trig_two_multi_select,
  // Waveform memory gate
  output logic                   snippet_access_gate,
  // Measurement inputs
  input  wire logic              supply_valid,
  input  wire logic [14:0]       supply_value,
  input  wire logic              drive_polarity,
  input  wire logic              mean_period_valid,
  input  wire logic [14:0]       mean_period_value,
  input  wire logic              live_period_valid,
  input  wire logic [14:0]       live_period_value,
  // Custom wave phase delay
  input  wire logic              custom_wave_select,
  output logic [7:0]             phase_delay_coarse,
  output logic                   phase_delay_freeze,
  output logic [2:0]             phase_delay_shift
);

  logic [3:0]  trig_seq [2];
  logic [1:0]  trig_multi;
  logic [1:0]  trig_edge [2];
  logic [1:0]  trig_level;
  logic        gate;
  logic [7:0]  supply_h;
  logic [6:0]  supply_l;
  logic        polarity;
  logic [7:0]  avg_h;
  logic [6:0]  avg_l;
  logic [7:0]  act_h;
  logic [6:0]  act_l;
  logic [7:0]  phase_h;
  logic        freeze;
  logic [2:0]  shift;
  logic [7:0]  reg_idx;
  logic        aligned;
  logic        setup;
  logic        wr_en;
  logic [7:0]  next_rdata;
  logic        next_err;
  logic [7:0]  rdata;
  logic        err;

  assign reg_idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);
  assign setup   = psel && !penable;
  // Only the low lane carries register data
  assign wr_en   = psel && penable && pwrite && pstrb[0];

  // Zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign prdata  = {24'h000000, rdata};
  assign pslverr = psel && penable && err;

  // Per-trigger config registers and edge detectors
  for (genvar i = 0; i < 2; i++) begin : g_trig
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        trig_seq[i]   <= (i == 0) ? TRIG_ONE_SEQ_RST : TRIG_TWO_SEQ_RST; // R1 R4
        trig_multi[i] <= MULTI_RST; // R2
        trig_edge[i]  <= EDGE_RST; // R3
      end else if (wr_en && aligned && reg_idx == ((i == 0) ? IDX_TRIG_ONE : IDX_TRIG_TWO)) begin
        trig_seq[i]   <= pwdata[SEQ_MSB:SEQ_LSB]; // R1 R4
        trig_multi[i] <= pwdata[MULTI_BIT]; // R2
        trig_edge[i]  <= pwdata[EDGE_MSB:EDGE_LSB]; // R3
      end
    end

    htr_trig_edge u_edge (
      .pclk       (pclk),
      .presetn    (presetn),
      .pin        (trigger_input[i]),
      .edge_sel   (trig_edge[i]),
      .level      (trig_level[i]),
      .trig_event (trig_event[i])
    ); // R16
  end

  assign trig_one_seq_select   = trig_seq[0];
  assign trig_one_multi_select = trig_multi[0];
  assign trig_two_seq_select   = trig_seq[1];
  assign trig_two_multi_select = trig_multi[1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate <= GATE_RST; // R6
    end else if (wr_en && aligned && reg_idx == IDX_MEM_LOCK) begin
      gate <= pwdata[GATE_BIT]; // R6
    end
  end

  assign snippet_access_gate = gate;

  // Supply readback holds its marker value until the first measurement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_h <= SUPPLY_H_RST; // R8
      supply_l <= SUPPLY_L_RST; // R8
    end else if (supply_valid) begin
      supply_h <= supply_value[14:LOW_W]; // R7
      supply_l <= supply_value[LOW_W-1:0]; // R7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      polarity <= POLARITY_RST; // R9
    end else begin
      polarity <= drive_polarity; // R9
    end
  end

  // Both halves load together so a read never mixes two measurements' halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_h <= AVG_H_RST; // R10
      avg_l <= AVG_L_RST; // R10
    end else if (mean_period_valid) begin
      avg_h <= mean_period_value[14:LOW_W]; // R10
      avg_l <= mean_period_value[LOW_W-1:0]; // R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_h <= ACT_H_RST; // R11
      act_l <= ACT_L_RST; // R11
    end else if (live_period_valid) begin
      act_h <= live_period_value[14:LOW_W]; // R11
      act_l <= live_period_value[LOW_W-1:0]; // R11
    end
  end

  // Reserved phase codes are stored as written; software keeps to legal ones
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_h <= PHASE_H_RST; // R12
      freeze  <= FREEZE_RST; // R13
      shift   <= SHIFT_RST; // R14
    end else if (wr_en && aligned) begin
      if (reg_idx == IDX_PHASE_H) begin
        phase_h <= pwdata[7:0]; // R12
      end
      if (reg_idx == IDX_PHASE_L) begin
        freeze <= pwdata[FREEZE_BIT]; // R13
        shift  <= pwdata[SHIFT_MSB:0]; // R14
      end
    end
  end

  // Outside custom wave mode the phase path sees neutral settings
  assign phase_delay_coarse = custom_wave_select ? phase_h : 8'h00; // R15
  assign phase_delay_freeze = custom_wave_select && freeze; // R15
  assign phase_delay_shift  = custom_wave_select ? shift : 3'h0; // R15

  always_comb begin
    next_rdata = UNMAPPED_RD;
    next_err   = 1'b0;
    if (!aligned) begin
      next_err = 1'b1;
    end else begin
      unique case (reg_idx)
        IDX_TRIG_ONE: next_rdata = {1'b0, trig_seq[0], trig_multi[0], trig_edge[0]}; // R1
        IDX_TRIG_TWO: next_rdata = {1'b0, trig_seq[1], trig_multi[1], trig_edge[1]}; // R4
        IDX_MEM_BASE: next_rdata = SNIPPET_BASE; // R5
        IDX_MEM_LOCK: next_rdata = {gate, 7'h00}; // R6
        IDX_SUPPLY_H: next_rdata = supply_h; // R7
        IDX_SUPPLY_L: next_rdata = {1'b0, supply_l}; // R7
        IDX_POLARITY: next_rdata = {7'h00, polarity}; // R9
        IDX_AVG_H:    next_rdata = avg_h; // R10
        IDX_AVG_L:    next_rdata = {1'b0, avg_l}; // R10
        IDX_ACT_H:    next_rdata = act_h; // R11
        IDX_ACT_L:    next_rdata = {1'b0, act_l}; // R11
        IDX_PHASE_H:  next_rdata = phase_h;
        IDX_PHASE_L:  next_rdata = {freeze, 4'h0, shift};
        default:      next_err   = 1'b1;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= 8'h00;
      err   <= 1'b0;
    end else if (setup) begin
      rdata <= pwrite ? 8'h00 : next_rdata;
      err   <= next_err;
    end
  end

  // Helper flags seen only by the checks below
  logic supply_seen;
  logic avg_seen;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supply_seen <= 1'b0;
      avg_seen    <= 1'b0;
    end else begin
      if (supply_valid) begin
        supply_seen <= 1'b1;
      end
      if (mean_period_valid) begin
        avg_seen <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence rd_access(logic [7:0] idx);
    psel && !penable && !pwrite && aligned && reg_idx == idx ##1 psel && penable;
  endsequence

  sequence wr_access(logic [7:0] idx);
    psel && penable && pwrite && pstrb[0] && aligned && reg_idx == idx;
  endsequence

  seq_one_write_a: assert property (wr_access(IDX_TRIG_ONE) |=>
    trig_one_seq_select == $past(pwdata[6:3]) && trig_edge[0] == $past(pwdata[1:0])) // R1
    else $error("trigger one config write not stored");

  multi_two_write_a: assert property (wr_access(IDX_TRIG_TWO) |=>
    trig_two_multi_select == $past(pwdata[2])) // R2
    else $error("trigger two mode write not stored");

  trig_two_read_a: assert property (rd_access(IDX_TRIG_TWO) |->
    prdata == {25'h0, trig_two_seq_select, trig_two_multi_select, trig_edge[1]}) // R4
    else $error("trigger two config read back wrong");

  base_read_a: assert property (rd_access(IDX_MEM_BASE) |-> prdata == 32'h00000084) // R5
    else $error("snippet base address read wrong");

  gate_write_a: assert property (wr_access(IDX_MEM_LOCK) |=>
    snippet_access_gate == $past(pwdata[7]) ##1 $stable(snippet_access_gate) || wr_en) // R6
    else $error("memory gate did not follow write");

  supply_capture_a: assert property (supply_valid |=>
    {supply_h, supply_l} == $past(supply_value)) // R7
    else $error("supply measurement not captured");

  supply_idle_a: assert property (!supply_seen |-> supply_h == 8'hFF && supply_l == 7'h7F) // R8
    else $error("supply readback left marker value early");

  polarity_track_a: assert property ($changed(drive_polarity) |=> polarity == $past(drive_polarity)) // R9
    else $error("polarity readback lagged");

  avg_capture_a: assert property (mean_period_valid |=> {avg_h, avg_l} == $past(mean_period_value)) // R10
    else $error("mean period readback wrong");

  avg_idle_a: assert property (!avg_seen |-> {avg_h, avg_l} == 15'h0000) // R10
    else $error("mean period left zero before a measurement");

  live_hold_a: assert property (!live_period_valid |=> $stable({act_h, act_l})) // R11
    else $error("live period changed without a measurement");

  phase_gate_a: assert property (!custom_wave_select |->
    phase_delay_coarse == 8'h00 && !phase_delay_freeze && phase_delay_shift == 3'h0) // R15
    else $error("phase settings applied outside custom wave mode");

  unmapped_err_a: assert property (psel && !penable && next_err ##1 psel && penable |-> pslverr)
    else $error("unmapped access gave no error");

  multi_one_write_a: assert property (wr_access(IDX_TRIG_ONE) |=>
    trig_one_multi_select == $past(pwdata[2])) // R2
    else $error("trigger one mode write not stored");

  edge_two_write_a: assert property (wr_access(IDX_TRIG_TWO) |=>
    trig_edge[1] == $past(pwdata[1:0])) // R3
    else $error("trigger two edge write not stored");

  seq_two_write_a: assert property (wr_access(IDX_TRIG_TWO) |=>
    trig_two_seq_select == $past(pwdata[6:3])) // R4
    else $error("trigger two sequence write not stored");

  trig_one_read_a: assert property (rd_access(IDX_TRIG_ONE) |->
    prdata == {25'h0, trig_one_seq_select, trig_one_multi_select, trig_edge[0]}) // R1
    else $error("trigger one config read back wrong");

  gate_read_a: assert property (rd_access(IDX_MEM_LOCK) |->
    prdata == {24'h0, snippet_access_gate, 7'h00}) // R6
    else $error("memory gate read back wrong");

  // Read data is taken at setup, so compare against the value seen then
  supply_read_a: assert property (rd_access(IDX_SUPPLY_L) |->
    prdata == {25'h0, $past(supply_l)}) // R7
    else $error("supply low part read back wrong");

  polarity_read_a: assert property (rd_access(IDX_POLARITY) |->
    prdata == {31'h0, $past(polarity)}) // R9
    else $error("polarity read back wrong");

  avg_read_a: assert property (rd_access(IDX_AVG_H) |-> prdata == {24'h0, $past(avg_h)}) // R10
    else $error("mean period high part read back wrong");

  live_capture_a: assert property (live_period_valid |=>
    {act_h, act_l} == $past(live_period_value)) // R11
    else $error("live period measurement not captured");

  live_read_a: assert property (rd_access(IDX_ACT_L) |-> prdata == {25'h0, $past(act_l)}) // R11
    else $error("live period low part read back wrong");

  wr_quiet_a: assert property (psel && penable && pwrite |-> prdata == 32'h00000000)
    else $error("write access drove read data");

  phase_pass_a: assert property (custom_wave_select |->
    phase_delay_coarse == phase_h && phase_delay_freeze == freeze && phase_delay_shift == shift) // R15
    else $error("phase settings not applied in custom wave mode");

endmodule

// [verif/haptic_trigger_status_regs_tb.sv]
/*
  Self-checking bench for the haptic trigger and status register bank.
  Drives APB, trigger pins and measurement strobes directly; assumes zero or
  more wait states on APB and byte address equal to four times the index.
*/
module haptic_trigger_status_regs_tb
  import htr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              pclk;
  logic              presetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata;
  logic [3:0]        pstrb;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [1:0]        trigger_input;
  logic [1:0]        trig_event;
  logic [3:0]        trig_one_seq_select;
  logic              trig_one_multi_select;
  logic [3:0]        trig_two_seq_select;
  logic              trig_two_multi_select;
  logic              snippet_access_gate;
  logic              supply_valid;
  logic [14:0]       supply_value;
  logic              drive_polarity;
  logic              mean_period_valid;
  logic [14:0]       mean_period_value;
  logic              live_period_valid;
  logic [14:0]       live_period_value;
  logic              custom_wave_select;
  logic [7:0]        phase_delay_coarse;
  logic              phase_delay_freeze;
  logic [2:0]        phase_delay_shift;

  int                fails;
  int                cmp_count;
  int                ev_cnt [2];
  logic [31:0]       rd;
  logic              err;

  htr_trigger_regs u_htr_trigger_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_input(trigger_input), .trig_event(trig_event),
    .trig_one_seq_select(trig_one_seq_select), .trig_one_multi_select(trig_one_multi_select),
    .trig_two_seq_select(trig_two_seq_select), .trig_two_multi_select(trig_two_multi_select),
    .snippet_access_gate(snippet_access_gate), .supply_valid(supply_valid),
    .supply_value(supply_value), .drive_polarity(drive_polarity),
    .mean_period_valid(mean_period_valid), .mean_period_value(mean_period_value),
    .live_period_valid(live_period_valid), .live_period_value(live_period_value),
    .custom_wave_select(custom_wave_select), .phase_delay_coarse(phase_delay_coarse),
    .phase_delay_freeze(phase_delay_freeze), .phase_delay_shift(phase_delay_shift)
  );

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Counting cycles high also catches a pulse that lasts too long
  always @(posedge pclk) begin
    if (trig_event[0] === 1'b1) ev_cnt[0]++;
    if (trig_event[1] === 1'b1) ev_cnt[1]++;
  end

  task automatic close_out();
    if (fails == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      fails++;
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     input logic [3:0] strb, output logic [31:0] rdat, output logic serr);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    pstrb   <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        $display("[FAIL] apb_ready expected 1 seen timeout");
        fails++;
        close_out();
      end
      @(posedge pclk);
    end
    rdat = prdata;
    serr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, {24'h0, d}, 4'hF, r, e);
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [7:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, 4'hF, r, e);
    check(nm, r, {24'h0, exp});
    check({nm, "_err"}, {31'h0, e}, 32'h0);
  endtask

  task automatic pin_set(input int p, input logic v);
    @(posedge pclk);
    trigger_input[p] <= v;
    repeat (10) @(posedge pclk);
  endtask

  task automatic meas(input int k, input logic [14:0] v);
    @(posedge pclk);
    case (k)
      0: begin
        supply_valid <= 1'b1;
        supply_value <= v;
      end
      1: begin
        mean_period_valid <= 1'b1;
        mean_period_value <= v;
      end
      default: begin
        live_period_valid <= 1'b1;
        live_period_value <= v;
      end
    endcase
    @(posedge pclk);
    supply_valid      <= 1'b0;
    mean_period_valid <= 1'b0;
    live_period_valid <= 1'b0;
  endtask

  logic [7:0]  rst_idx [13] = '{8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h2F, 8'h43,
                                8'h44, 8'h45, 8'h46, 8'h47, 8'h48, 8'h49};
  logic [7:0]  rst_val [13] = '{8'h08, 8'h10, 8'h84, 8'h80, 8'hFF, 8'h7F, 8'h00,
                                8'h00, 8'h00, 8'h21, 8'h4F, 8'h25, 8'h05};
  logic [7:0]  hi_idx  [3]  = '{8'h2E, 8'h44, 8'h46};
  logic [14:0] m_val   [3]  = '{15'h5A3C, 15'h0081, 15'h7FFE};

  initial begin
    int          b0;
    int          b1;
    logic [7:0]  cfg;
    logic        rise_ok;
    logic        fall_ok;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    trigger_input = 2'b00;
    supply_valid = 1'b0;
    supply_value = 15'h0;
    drive_polarity = 1'b0;
    mean_period_valid = 1'b0;
    mean_period_value = 15'h0;
    live_period_valid = 1'b0;
    live_period_value = 15'h0;
    custom_wave_select = 1'b0;
    fails = 0;
    cmp_count = 0;
    ev_cnt = '{0, 0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of every register and of the configuration outputs
    for (int i = 0; i < 13; i++) begin
      rd_chk("reset_value", rst_idx[i], rst_val[i]);
    end
    check("seq_one_rst", {28'h0, trig_one_seq_select}, 32'h1);
    check("seq_two_rst", {28'h0, trig_two_seq_select}, 32'h2);
    check("multi_rst", {30'h0, trig_one_multi_select, trig_two_multi_select}, 32'h0);
    check("gate_rst", {31'h0, snippet_access_gate}, 32'h1);
    check("phase_off", {20'h0, phase_delay_coarse, phase_delay_freeze, phase_delay_shift}, 32'h0);
    // Field write and readback
    wr_reg(8'h2A, 8'h66);
    rd_chk("cfg_one", 8'h2A, 8'h66);
    check("seq_one", {27'h0, trig_one_seq_select, trig_one_multi_select}, 32'h19);
    wr_reg(8'h2B, 8'h7D);
    rd_chk("cfg_two", 8'h2B, 8'h7D);
    check("seq_two", {27'h0, trig_two_seq_select, trig_two_multi_select}, 32'h1F);
    // Read-only places ignore writes, unmapped place answers with an error
    wr_reg(8'h2C, 8'h00);
    rd_chk("base_ro", 8'h2C, 8'h84);
    wr_reg(8'h2E, 8'h12);
    rd_chk("supply_ro", 8'h2E, 8'hFF);
    apb(1'b0, 8'h30, 32'h0, 4'hF, rd, err);
    check("unmapped_err", {31'h0, err}, 32'h1);
    check("unmapped_data", rd, 32'h0);
    // Edge selection on both pins, every code including the unused one
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        cfg = {1'b0, 4'h3, 1'b0, c[1:0]};
        wr_reg(p == 0 ? 8'h2A : 8'h2B, cfg);
        rise_ok = (c == 0) || (c == 2);
        fall_ok = (c == 1) || (c == 2);
        b0 = ev_cnt[p];
        b1 = ev_cnt[1 - p];
        pin_set(p, 1'b1);
        check("rise_events", ev_cnt[p] - b0, {31'h0, rise_ok});
        b0 = ev_cnt[p];
        pin_set(p, 1'b0);
        check("fall_events", ev_cnt[p] - b0, {31'h0, fall_ok});
        check("other_pin", ev_cnt[1 - p] - b1, 32'h0);
      end
    end
    // Memory gate
    wr_reg(8'h2D, 8'h00);
    rd_chk("gate_lock", 8'h2D, 8'h00);
    check("gate_locked", {31'h0, snippet_access_gate}, 32'h0);
    wr_reg(8'h2D, 8'h80);
    // The write lands at the access edge; look one edge later
    @(posedge pclk);
    check("gate_open", {31'h0, snippet_access_gate}, 32'h1);
    // Measurement pairs split as high times 128 plus low
    for (int k = 0; k < 3; k++) begin
      meas(k, m_val[k]);
      rd_chk("meas_high", hi_idx[k], m_val[k][14:7]);
      rd_chk("meas_low", hi_idx[k] + 8'h01, {1'b0, m_val[k][6:0]});
    end
    @(posedge pclk);
    drive_polarity <= 1'b1;
    repeat (2) @(posedge pclk);
    rd_chk("polarity_one", 8'h43, 8'h01);
    drive_polarity <= 1'b0;
    repeat (2) @(posedge pclk);
    rd_chk("polarity_zero", 8'h43, 8'h00);
    // Phase delay settings act only in custom wave mode
    custom_wave_select <= 1'b1;
    @(posedge pclk);
    @(negedge pclk);
    check("phase_track", {20'h0, phase_delay_coarse, phase_delay_freeze, phase_delay_shift}, 32'h255);
    wr_reg(8'h48, 8'h00);
    wr_reg(8'h49, 8'h80);
    apb(1'b1, 8'h48, 32'h25, 4'hE, rd, err);
    rd_chk("phase_high", 8'h48, 8'h00);
    rd_chk("phase_low", 8'h49, 8'h80);
    check("phase_wide", {20'h0, phase_delay_coarse, phase_delay_freeze, phase_delay_shift}, 32'h008);
    custom_wave_select <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    check("phase_normal", {31'h0, phase_delay_freeze}, 32'h0);
    close_out();
  end
endmodule
